// *** inv_reg_regs.svh ***
/*
  constants for the inverting capture register: width, reset values
  and timing figures.
  assumes: included by bare name from every design file that needs it.
*/
`ifndef INV_REG_REGS_SVH
`define INV_REG_REGS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define INV_REG_WIDTH      8
`define INV_REG_SYNC_DEPTH 2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define INV_REG_OUT_RST    8'h00
`define INV_REG_OE_RST     1'b0
`define INV_REG_PIN_RST    1'b0
`define INV_REG_OEN_RST    1'b1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define INV_REG_CLK_PERIOD_NS 25
`define INV_REG_SYNC_LAT   2
`define INV_REG_PIN_TO_OUT 4

`endif

// *** inv_reg_pkg.sv ***
/*
  types shared by the inverting capture register and its synchroniser.
  assumes: compiled after inv_reg_regs.svh and before the modules.
*/
`default_nettype none
`include "inv_reg_regs.svh"

package inv_reg_pkg;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef logic [`INV_REG_WIDTH-1:0] data_t;

  typedef struct packed
  {
    logic  capture_clk;
    logic  oe_n;
    data_t din;
  } pin_group_t;

  typedef struct packed
  {
    logic  oe;
    data_t data;
  } bus_drive_t;

  // ----------------------------------------------------------------------
  // load state, gray coded
  // ----------------------------------------------------------------------
  typedef enum logic [0:0]
  {
    LOAD_EMPTY  = 1'b0,
    LOAD_VALID  = 1'b1
  } load_state_t;

endpackage

`default_nettype wire

// *** sync_2ff.sv ***
/*
  two-stage synchroniser for a group of asynchronous pin levels.
  assumes: one clock; the first stage is read only by the second.
*/
`default_nettype none
`include "inv_reg_regs.svh"

module sync_2ff
#(
  parameter int                WIDTH   = 1,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
)
(
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] stable_ff;
  logic [WIDTH-1:0] nxt_stable;

  always_comb
  begin
    nxt_meta   = async_in;
    nxt_stable = meta_ff;
    if (reset_in)
    begin
      nxt_meta   = RST_VAL;
      nxt_stable = RST_VAL;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    meta_ff   <= nxt_meta;
    stable_ff <= nxt_stable;
  end

  assign sync_out = stable_ff;

endmodule

`default_nettype wire

// *** inv_capture_reg.sv ***
/*
  eight-bit capture register with inverted, enable-gated bus outputs,
  rebuilt as synchronous logic on a fast system clock.
  assumes: capture_clk, oe_n and din are asynchronous pins sampled at
  40 mhz; the pad ring turns inv_bus_out plus inv_bus_oe_out into a
  three-state driver (oe high means driving).
*/
// Summary of operation
// - eight storage bits, all loaded together on one capture edge
// - each rising capture edge stores the level on each data input
// - without a rising capture edge the stored bits never change
// - driven outputs show the complement of each stored bit, zero until a capture follows reset
// - enable low makes all eight outputs drive inverted data
// - enable high floats all eight outputs, no drive at all
// - one enable gates all eight outputs, independent of capture
// - capture continues while outputs float; new data shows on enable
// - outputs stay floated while power (reset) is applied
`default_nettype none
`include "inv_reg_regs.svh"

module inv_capture_reg
(
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          capture_clk_in,
  input  wire logic                          oe_n_in,
  input  wire logic [`INV_REG_WIDTH-1:0]     din_in,
  output var  logic [`INV_REG_WIDTH-1:0]     inv_bus_out,
  output var  logic                          inv_bus_oe_out
);

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  inv_reg_pkg::pin_group_t pins_raw;
  inv_reg_pkg::pin_group_t pins_s;

  assign pins_raw.capture_clk = capture_clk_in;
  assign pins_raw.oe_n        = oe_n_in;
  assign pins_raw.din         = din_in;

  // clock, enable and data share one synchroniser so their latency
  // matches; the edge then samples data from the same pin instant
  sync_2ff
  #(
    .WIDTH   ($bits(inv_reg_pkg::pin_group_t)),
    .RST_VAL ({`INV_REG_PIN_RST, `INV_REG_OEN_RST, `INV_REG_OUT_RST})
  )
  u_pin_sync
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   (pins_raw),
    .sync_out   (pins_s)
  );

  // ----------------------------------------------------------------------
  // capture edge detection
  // ----------------------------------------------------------------------
  logic cap_prev_ff;
  logic nxt_cap_prev;
  logic cap_edge;

  always_comb
  begin
    nxt_cap_prev = pins_s.capture_clk;
    if (reset_in)
    begin
      nxt_cap_prev = `INV_REG_PIN_RST;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    cap_prev_ff <= nxt_cap_prev;
  end

  // only low-to-high counts; a level held high is not a new edge
  assign cap_edge = pins_s.capture_clk & ~cap_prev_ff;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  inv_reg_pkg::data_t       store_ff;
  inv_reg_pkg::data_t       nxt_store;
  inv_reg_pkg::load_state_t load_ff;
  inv_reg_pkg::load_state_t nxt_load;

  always_comb
  begin
    nxt_store = store_ff;
    if (cap_edge)
    begin
      nxt_store = pins_s.din;
    end
  end

  // storage left unreset
  // a reset here would fake a known value the device never has
  always_ff @(posedge ref_clk_in)
  begin
    store_ff <= nxt_store;
  end

  always_comb
  begin
    nxt_load = load_ff;
    unique case (load_ff)
      inv_reg_pkg::LOAD_EMPTY:
      begin
        if (cap_edge)
        begin
          nxt_load = inv_reg_pkg::LOAD_VALID;
        end
      end
      inv_reg_pkg::LOAD_VALID:
      begin
        nxt_load = inv_reg_pkg::LOAD_VALID;
      end
    endcase
    if (reset_in)
    begin
      nxt_load = inv_reg_pkg::LOAD_EMPTY;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    load_ff <= nxt_load;
  end

  // ----------------------------------------------------------------------
  // bus drive
  // ----------------------------------------------------------------------
  inv_reg_pkg::bus_drive_t bus_ff;
  inv_reg_pkg::bus_drive_t nxt_bus;

  always_comb
  begin
    nxt_bus.data = `INV_REG_OUT_RST;
    // invert stored bits
    // limitation: before the first capture the data reads as zero
    if (load_ff == inv_reg_pkg::LOAD_VALID)
    begin
      nxt_bus.data = ~store_ff;
    end
    // shared enable
    // enable follows its pin whatever the capture clock does
    nxt_bus.oe = ~pins_s.oe_n;
    if (reset_in)
    begin
      nxt_bus.data = `INV_REG_OUT_RST;
      nxt_bus.oe   = `INV_REG_OE_RST;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    bus_ff <= nxt_bus;
  end

  assign inv_bus_out    = bus_ff.data;
  assign inv_bus_oe_out = bus_ff.oe;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_store_all_bits:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cap_edge |=> store_ff == $past(pins_s.din))
    else $error("stored word differs from sampled data");

  a_store_hold_idle:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !cap_edge && load_ff == inv_reg_pkg::LOAD_VALID |=> $stable(store_ff))
    else $error("stored word changed without a capture edge");

  a_out_inverted:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      load_ff == inv_reg_pkg::LOAD_VALID |=> inv_bus_out == ~$past(store_ff))
    else $error("bus data is not the complement of the store");

  a_enable_drive:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !pins_s.oe_n |=> inv_bus_oe_out)
    else $error("enable low did not drive the bus");

  a_enable_float:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      pins_s.oe_n [*2] |=> !inv_bus_oe_out)
    else $error("enable high did not float the bus");

  a_enable_no_clock:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      $changed(pins_s.oe_n) && !cap_edge |=> $changed(inv_bus_oe_out))
    else $error("enable change was not passed through without capture");

  a_load_while_float:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cap_edge && pins_s.oe_n |-> ##2 inv_bus_out == ~$past(pins_s.din, 2))
    else $error("capture while floated lost the new word");

  a_reset_floats:
    assert property (@(posedge ref_clk_in)
      $past(reset_in) |-> !inv_bus_oe_out)
    else $error("bus driven during reset");

  a_empty_reads_zero:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      load_ff == inv_reg_pkg::LOAD_EMPTY && !cap_edge
        |=> ##1 inv_bus_out == `INV_REG_OUT_RST)
    else $error("bus data not zero before the first capture");

  a_first_capture:
    assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cap_edge |=> load_ff == inv_reg_pkg::LOAD_VALID ##1
        inv_bus_out == ~$past(pins_s.din, 2))
    else $error("first capture did not load all eight bits");

endmodule

`default_nettype wire

// *** shared_bus_model.sv ***
/*
  behavioural model of the shared three-state bus fed by the register.
  assumes: the drive struct comes straight from the register's pads.
*/
`default_nettype none

module shared_bus_model
(
  input  wire inv_reg_pkg::bus_drive_t drive_in,
  input  wire logic                    ref_clk_in,
  output var  inv_reg_pkg::data_t      bus_out,
  output var  logic                    driven_out
);
  timeunit 1ns;
  timeprecision 1ps;

  inv_reg_pkg::data_t last_ff;

  // no keeper on this bus: a floated bus shows the opposite of the last
  // driven word, so a read of stale data is never mistaken for a good one
  always_ff @(posedge ref_clk_in)
  begin
    if (drive_in.oe)
    begin
      last_ff <= drive_in.data;
    end
  end

  always_comb
  begin
    driven_out = drive_in.oe;
    bus_out    = drive_in.oe ? drive_in.data : ~last_ff;
  end
endmodule

`default_nettype wire

// *** octal_inverting_tristate_register_tb_top.sv ***
/*
  self-checking bench for the inverting capture register.
  assumes: design files and the bus model are compiled first.
*/
`default_nettype none

module octal_inverting_tristate_register_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic                    ref_clk_in     = 1'b0;
  logic                    reset_in       = 1'b1;
  logic                    capture_clk_in = 1'b0;
  logic                    oe_n_in        = 1'b1;
  inv_reg_pkg::data_t      din_in         = 8'h00;
  inv_reg_pkg::data_t      inv_bus_out;
  logic                    inv_bus_oe_out;
  inv_reg_pkg::bus_drive_t drv;
  inv_reg_pkg::data_t      bus_level;
  logic                    bus_driven;
  int                      fails       = 0;
  int                      check_count = 0;
  int                      cycles      = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;

  assign drv = {inv_bus_oe_out, inv_bus_out};

  inv_capture_reg inv_capture_reg_i
  (
    .ref_clk_in     (ref_clk_in),
    .reset_in       (reset_in),
    .capture_clk_in (capture_clk_in),
    .oe_n_in        (oe_n_in),
    .din_in         (din_in),
    .inv_bus_out    (inv_bus_out),
    .inv_bus_oe_out (inv_bus_oe_out)
  );

  shared_bus_model shared_bus_model_i
  (
    .drive_in   (drv),
    .ref_clk_in (ref_clk_in),
    .bus_out    (bus_level),
    .driven_out (bus_driven)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
  begin
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // the whole run is about 150 cycles; this only cuts a hang
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fails++;
      close_out();
    end
  end

  task automatic cyc(input int n);
  begin
    repeat (n) @(posedge ref_clk_in);
  end
  endtask

  task automatic cmp8(input string what, input inv_reg_pkg::data_t exp,
                      input inv_reg_pkg::data_t got);
  begin
    check_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
  begin
    check_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %b seen %b", what, exp, got);
      fails++;
    end
  end
  endtask

  // din changes to its inverse after the capture to catch a leaky store
  task automatic cap(input inv_reg_pkg::data_t d);
  begin
    @(posedge ref_clk_in);
    din_in <= d;
    @(posedge ref_clk_in);
    capture_clk_in <= 1'b1;
    cyc(2);
    capture_clk_in <= 1'b0;
    din_in <= ~d;
    cyc(6);
  end
  endtask

  task automatic set_oe_n(input logic v);
  begin
    @(posedge ref_clk_in);
    oe_n_in <= v;
    cyc(5);
  end
  endtask

  task automatic chk_bus(input inv_reg_pkg::data_t d);
  begin
    #1;
    cmp1("bus_driven", 1'b1, bus_driven);
    cmp8("bus_level", ~d, bus_level);
  end
  endtask

  task automatic chk_float();
  begin
    #1;
    cmp1("inv_bus_oe_out", 1'b0, inv_bus_oe_out);
    cmp1("bus_driven", 1'b0, bus_driven);
  end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_load();
    inv_reg_pkg::data_t vals [6];
  begin
    vals = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h01, 8'h80};
    set_oe_n(1'b0);
    foreach (vals[i])
    begin
      cap(vals[i]);
      chk_bus(vals[i]);
    end
  end
  endtask

  task automatic t_hold();
  begin
    cap(8'h3c);
    @(posedge ref_clk_in);
    din_in <= 8'h96;
    cyc(3);
    din_in <= 8'h0f;
    cyc(3);
    chk_bus(8'h3c);
    // a level held high: only its rise stores, later data is ignored
    @(posedge ref_clk_in);
    capture_clk_in <= 1'b1;
    cyc(3);
    din_in <= 8'h69;
    cyc(6);
    chk_bus(8'h0f);
  end
  endtask

  task automatic t_float();
  begin
    @(posedge ref_clk_in);
    capture_clk_in <= 1'b0;
    set_oe_n(1'b1);
    chk_float();
    cap(8'hc3);
    chk_float();
    cmp8("inv_bus_out", ~8'hc3, inv_bus_out);
    set_oe_n(1'b0);
    chk_bus(8'hc3);
  end
  endtask

  task automatic t_reset_mid();
  begin
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    cyc(5);
    chk_float();
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    cyc(6);
    cmp8("inv_bus_out", 8'h00, inv_bus_out);
    cap(8'h69);
    chk_bus(8'h69);
  end
  endtask

  initial
  begin
    cyc(5);
    reset_in <= 1'b0;
    #1;
    chk_float();
    cyc(3);
    t_load();
    t_hold();
    t_float();
    t_reset_mid();
    close_out();
  end
endmodule

`default_nettype wire
